/* hw/ifl_pkg.sv */
// Constants for the interrupt flag logic: register map, field positions, reset values.
// Assumes an AXI4-Lite master with 32-bit data; all registers are word aligned.
package ifl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PERIPH_FLAG = 8'h04;
  localparam logic [7:0] ADDR_PERIPH_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_COMPARATOR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_OPTION = 8'h10;
  localparam logic [7:0] ADDR_CORE_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_TIMER_EN = 5;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_PORT_EN = 3;
  localparam int BIT_TIMER_FLAG = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_PORT_FLAG = 0;
  localparam int BIT_CMP_FLAG = 6;
  localparam int BIT_CMP_EN = 6;
  localparam int BIT_CMP_ONE_OUT = 6;
  localparam int BIT_CMP_TWO_OUT = 7;
  localparam int BIT_EDGE_SEL = 6;
  localparam int BIT_STAT_SLEEP = 0;
  localparam int BIT_STAT_IRQ = 1;
  localparam int BIT_STAT_VECTOR = 2;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAG = 8'h00;
  localparam logic [7:0] RST_PERIPH_ENABLE = 8'h00;
  localparam logic [2:0] RST_CMP_MODE = 3'h0;
  localparam logic [2:0] CMP_MODE_OFF = 3'h7;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hw/ifl_edge_detect.sv */
// One sampled input with previous-value latch and change/edge pulses.
// Assumes the input is synchronous to i_clk.
`timescale 1ns/1ns
module ifl_edge_detect (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Sample
  input wire logic i_level,
  input wire logic i_reload,
  // Results
  output logic o_prev,
  output logic o_change,
  output logic o_rise,
  output logic o_fall
);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prev <= 1'b0;
    end else begin
      o_prev <= i_reload ? i_level : o_prev;
    end
  end

  assign o_change = i_level != o_prev;
  assign o_rise = i_level & ~o_prev;
  assign o_fall = ~i_level & o_prev;

endmodule

/* hw/ifl_top.sv */
// Interrupt flag and enable logic: comparator change, external edge,
// timer overflow and port change sources, with sleep wake-up.
// Assumes synchronous inputs and an AXI4-Lite master on the register bus.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module ifl_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Event sources
  input wire logic i_cmp_one_raw,
  input wire logic i_cmp_two_raw,
  input wire logic i_ext_irq_pin,
  input wire logic [7:0] i_timer_zero_count,
  input wire logic [3:0] i_io_port_upper,
  // Core side
  input wire logic i_sleep_enter,
  output logic o_irq,
  output logic o_wake,
  output logic o_vector,
  output logic o_sleeping,
  output logic o_cmp_power
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] irq_control_reg;
  logic [7:0] periph_enable_reg;
  logic [2:0] comparator_mode_field;
  logic [7:0] option_reg;
  logic cmp_change_flag;
  logic [7:0] timer_prev;
  logic sleeping;

  // Bus state
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic rd_go;

  assign wr_go = aw_held & w_held & ~o_bvalid;
  assign rd_go = i_arvalid & o_arready;

  // ----------------------------------------------------------------
  // Source detectors
  // ----------------------------------------------------------------
  logic cmp_on;
  logic cmp_one_output;
  logic cmp_two_output;
  logic cmp_access;
  logic cmp_one_chg;
  logic cmp_two_chg;
  logic ext_rise;
  logic ext_fall;
  logic [3:0] port_chg;
  logic cmp_one_latched;
  logic cmp_two_latched;

  // Comparators off in mode 111 only; on through reset (mode forced to 000 there)
  assign cmp_on = comparator_mode_field != ifl_pkg::CMP_MODE_OFF;
  assign cmp_one_output = cmp_on & i_cmp_one_raw;
  assign cmp_two_output = cmp_on & i_cmp_two_raw;
  assign cmp_access = (wr_go && aw_addr == ifl_pkg::ADDR_COMPARATOR_CONTROL) ||
                      (rd_go && i_araddr == ifl_pkg::ADDR_COMPARATOR_CONTROL);

  // Latched outputs only follow the comparators on an access, so a mismatch
  // persists until software touches comparator control
  ifl_edge_detect u_cmp_one (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_level(cmp_one_output),
    .i_reload(cmp_access),
    .o_prev(cmp_one_latched),
    .o_change(cmp_one_chg),
    .o_rise(),
    .o_fall()
  );

  ifl_edge_detect u_cmp_two (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_level(cmp_two_output),
    .i_reload(cmp_access),
    .o_prev(cmp_two_latched),
    .o_change(cmp_two_chg),
    .o_rise(),
    .o_fall()
  );

  ifl_edge_detect u_ext (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_level(i_ext_irq_pin),
    .i_reload(1'b1),
    .o_prev(),
    .o_change(),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_port
      ifl_edge_detect u_port (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_level(i_io_port_upper[gi]),
        .i_reload(1'b1),
        .o_prev(),
        .o_change(port_chg[gi]),
        .o_rise(),
        .o_fall()
      );
    end
  endgenerate

  logic cmp_event;
  logic ext_event;
  logic timer_event;
  logic port_event;

  // Never masked by enables; the read race is tolerated by never dropping events
  assign cmp_event = cmp_one_chg | cmp_two_chg;
  assign ext_event = option_reg[ifl_pkg::BIT_EDGE_SEL] ? ext_rise : ext_fall;
  assign timer_event = (timer_prev == ifl_pkg::TIMER_MAX) &&
                       (i_timer_zero_count == 8'h00);
  assign port_event = |port_chg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_prev <= 8'h00;
    end else begin
      timer_prev <= i_timer_zero_count;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_ctl;
  logic wr_pfl;
  logic wr_pen;
  logic wr_cmc;
  logic wr_opt;

  assign wr_ctl = wr_go && w_strb[0] && aw_addr == ifl_pkg::ADDR_IRQ_CONTROL;
  assign wr_pfl = wr_go && w_strb[0] && aw_addr == ifl_pkg::ADDR_PERIPH_FLAG;
  assign wr_pen = wr_go && w_strb[0] && aw_addr == ifl_pkg::ADDR_PERIPH_ENABLE;
  assign wr_cmc = wr_go && w_strb[0] && aw_addr == ifl_pkg::ADDR_COMPARATOR_CONTROL;
  assign wr_opt = wr_go && w_strb[0] && aw_addr == ifl_pkg::ADDR_OPTION;

  // ----------------------------------------------------------------
  // Flags and enables
  // ----------------------------------------------------------------
  logic [7:0] next_ctl;

  always_comb begin
    next_ctl = wr_ctl ? w_data[7:0] : irq_control_reg;
    // Hardware sets applied after the write so a same-cycle clear loses
    if (timer_event) begin
      next_ctl[ifl_pkg::BIT_TIMER_FLAG] = 1'b1;
    end
    if (ext_event) begin
      next_ctl[ifl_pkg::BIT_EXT_FLAG] = 1'b1;
    end
    if (port_event) begin
      next_ctl[ifl_pkg::BIT_PORT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_control_reg <= ifl_pkg::RST_IRQ_CONTROL;
    end else begin
      irq_control_reg <= next_ctl;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_change_flag <= 1'b0;
    end else if (cmp_event) begin
      cmp_change_flag <= 1'b1;
    end else if (wr_pfl) begin
      cmp_change_flag <= w_data[ifl_pkg::BIT_CMP_FLAG];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      periph_enable_reg <= ifl_pkg::RST_PERIPH_ENABLE;
    end else if (wr_pen) begin
      periph_enable_reg <= w_data[7:0];
    end
  end

  // Sleep does not touch this register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      comparator_mode_field <= ifl_pkg::RST_CMP_MODE;
    end else if (wr_cmc) begin
      comparator_mode_field <= w_data[2:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      option_reg <= ifl_pkg::RST_OPTION;
    end else if (wr_opt) begin
      option_reg <= w_data[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Request, wake and vector
  // ----------------------------------------------------------------
  logic core_pending;
  logic cmp_pending;
  logic any_pending;
  logic next_irq;

  assign core_pending =
    (irq_control_reg[ifl_pkg::BIT_TIMER_EN] & irq_control_reg[ifl_pkg::BIT_TIMER_FLAG]) |
    (irq_control_reg[ifl_pkg::BIT_EXT_EN] & irq_control_reg[ifl_pkg::BIT_EXT_FLAG]) |
    (irq_control_reg[ifl_pkg::BIT_PORT_EN] & irq_control_reg[ifl_pkg::BIT_PORT_FLAG]);
  assign cmp_pending = irq_control_reg[ifl_pkg::BIT_PERIPH_EN] &
                       periph_enable_reg[ifl_pkg::BIT_CMP_EN] & cmp_change_flag;
  assign any_pending = core_pending | cmp_pending;
  assign next_irq = irq_control_reg[ifl_pkg::BIT_GLOBAL_EN] & any_pending;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

  // Wake ignores the global enable; comparators keep running while asleep
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sleeping <= 1'b0;
      o_wake <= 1'b0;
      o_vector <= 1'b0;
    end else begin
      o_wake <= 1'b0;
      o_vector <= 1'b0;
      if (sleeping && any_pending) begin
        sleeping <= 1'b0;
        o_wake <= 1'b1;
        o_vector <= irq_control_reg[ifl_pkg::BIT_GLOBAL_EN];
      end else if (i_sleep_enter) begin
        sleeping <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sleeping <= 1'b0;
      o_cmp_power <= 1'b0;
    end else begin
      o_sleeping <= sleeping | (i_sleep_enter & ~(sleeping & any_pending));
      o_cmp_power <= cmp_on;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= ifl_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr <= ifl_pkg::ADDR_CORE_STATUS && aw_addr[1:0] == 2'h0) ?
                   ifl_pkg::RESP_OKAY : ifl_pkg::RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_ok;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (i_araddr)
      ifl_pkg::ADDR_IRQ_CONTROL: rd_word[7:0] = irq_control_reg;
      ifl_pkg::ADDR_PERIPH_FLAG: rd_word[ifl_pkg::BIT_CMP_FLAG] = cmp_change_flag;
      ifl_pkg::ADDR_PERIPH_ENABLE: rd_word[7:0] = periph_enable_reg;
      ifl_pkg::ADDR_COMPARATOR_CONTROL: begin
        rd_word[ifl_pkg::BIT_CMP_TWO_OUT] = cmp_two_output;
        rd_word[ifl_pkg::BIT_CMP_ONE_OUT] = cmp_one_output;
        rd_word[2:0] = comparator_mode_field;
      end
      ifl_pkg::ADDR_OPTION: rd_word[7:0] = option_reg;
      ifl_pkg::ADDR_CORE_STATUS: begin
        rd_word[ifl_pkg::BIT_STAT_SLEEP] = sleeping;
        rd_word[ifl_pkg::BIT_STAT_IRQ] = next_irq;
        rd_word[ifl_pkg::BIT_STAT_VECTOR] = cmp_one_latched ^ cmp_two_latched;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= ifl_pkg::RESP_OKAY;
    end else begin
      if (rd_go) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= rd_ok ? ifl_pkg::RESP_OKAY : ifl_pkg::RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule

/* tb/ifl_monitor.sv */
// Port checker for the interrupt flag block: bus hold rules and sleep/wake.
// Assumes it is bound into ifl_top and sees its ports only.
`timescale 1ns/1ns
module ifl_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Bus
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  // Core side
  input wire logic i_sleep_enter,
  input wire logic o_wake,
  input wire logic o_vector,
  input wire logic o_sleeping,
  input wire logic o_cmp_power
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_write_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted during response");
  a_read_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted during response");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  a_wake_sleeping: assert property (o_wake |-> $past(o_sleeping))
    else $error("wake without sleep");
  a_vector_wake: assert property (o_vector |-> o_wake)
    else $error("vector without wake");
  a_power_reset: assert property ($rose(i_nrst) |=> o_cmp_power)
    else $error("comparators off after reset");
  a_sleep_entry: assert property (i_sleep_enter && !o_sleeping |-> ##[1:2] o_sleeping)
    else $error("sleep not entered");
endmodule

bind ifl_top ifl_monitor u_mon (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_bready(i_bready),
  .i_rready(i_rready),
  .o_awready(o_awready),
  .o_wready(o_wready),
  .o_bvalid(o_bvalid),
  .o_bresp(o_bresp),
  .o_arready(o_arready),
  .o_rvalid(o_rvalid),
  .o_rdata(o_rdata),
  .i_sleep_enter(i_sleep_enter),
  .o_wake(o_wake),
  .o_vector(o_vector),
  .o_sleeping(o_sleeping),
  .o_cmp_power(o_cmp_power)
);

/* tb/ifl_core_model.sv */
// Core sequencer model: issues the sleep instruction and counts wake-ups.
// Assumes the bench pulses i_go for one cycle to request sleep.
`timescale 1ns/1ns
module ifl_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Control and observation
  input wire logic i_go,
  input wire logic i_wake,
  input wire logic i_vector,
  output logic o_sleep_enter,
  output logic [31:0] o_wakes,
  output logic [31:0] o_vectors
);
  // Sleep is a one-cycle instruction, so the request is a single pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sleep_enter <= 1'b0;
    end else begin
      o_sleep_enter <= i_go;
    end
  end

  // Vectoring counted apart from wake so a wake without branch shows
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wakes <= 32'h0;
      o_vectors <= 32'h0;
    end else begin
      o_wakes <= o_wakes + {31'h0, i_wake};
      o_vectors <= o_vectors + {31'h0, i_vector};
    end
  end
endmodule

/* tb/interrupt_flag_logic_test.sv */
// Self-checking bench for ifl_top over AXI4-Lite with a core model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ns
module interrupt_flag_logic_test;
  logic i_clk = 0, i_nrst = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0] awa = 8'h0, ara = 8'h0, tmr = 8'h0;
  logic [31:0] wd = 32'h0, rdat, wk, vc, o_rdata;
  logic [1:0] bresp, rresp, o_bresp, o_rresp;
  logic c1 = 0, c2 = 0, pin = 0, go = 0, slp;
  logic [3:0] nib = 4'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_wake, o_vector;
  logic o_sleeping, o_cmp_power;
  int n_fail = 0, comparisons = 0, cyc = 0, seed = 53296;
  logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, ifl_pkg::RST_OPTION, 8'h00};

  always #2 i_clk = ~i_clk;

  ifl_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(awv), .o_awready(o_awready),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(o_wready), .i_wdata(wd), .i_wstrb(4'hF),
    .o_bvalid(o_bvalid), .i_bready(bready), .o_bresp(o_bresp), .i_arvalid(arv),
    .o_arready(o_arready), .i_araddr(ara), .o_rvalid(o_rvalid), .i_rready(rready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .i_cmp_one_raw(c1), .i_cmp_two_raw(c2),
    .i_ext_irq_pin(pin), .i_timer_zero_count(tmr), .i_io_port_upper(nib),
    .i_sleep_enter(slp), .o_irq(o_irq), .o_wake(o_wake), .o_vector(o_vector),
    .o_sleeping(o_sleeping), .o_cmp_power(o_cmp_power));

  ifl_core_model u_core (.i_clk(i_clk), .i_nrst(i_nrst), .i_go(go), .i_wake(o_wake),
    .i_vector(o_vector), .o_sleep_enter(slp), .o_wakes(wk), .o_vectors(vc));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task end_sim;
    $display("Comparisons %0d, errors %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic at, dt;
    at = 0;
    dt = 0;
    @(posedge i_clk);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= {24'h0, d};
    bready <= 1;
    while (!(at && dt)) begin
      @(posedge i_clk);
      if (!at && o_awready) begin at = 1; awv <= 0; end
      if (!dt && o_wready) begin dt = 1; wv <= 0; end
    end
    while (o_bvalid !== 1'b1) @(posedge i_clk);
    bresp = o_bresp;
    bready <= 0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge i_clk);
    arv <= 1;
    ara <= a;
    rready <= 1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    arv <= 0;
    while (o_rvalid !== 1'b1) @(posedge i_clk);
    rdat = o_rdata;
    rresp = o_rresp;
    rready <= 0;
  endtask

  task rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rdat, {24'h0, e});
  endtask

  function automatic logic [7:0] ext_exp(input logic sel, input logic rise);
    return (sel == rise) ? 8'h02 : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    tmr <= 8'($random(seed)) & 8'h7F;
    tick(16);
    i_nrst <= 1;
    tick(2);
    for (int i = 0; i < 6; i++) begin
      rc(adr[i], rv[i]);
      chk(rresp, (i == 5) ? ifl_pkg::RESP_SLVERR : ifl_pkg::RESP_OKAY);
    end
    wr(8'h18, 8'hFF);
    chk(bresp, ifl_pkg::RESP_SLVERR);
    tmr <= 8'hFF;
    tick(1);
    tmr <= 8'h00;
    tick(4);
    rc(8'h00, 8'h04);
    wr(8'h00, 8'hA4);
    tick(3);
    chk(o_irq, 1);
    wr(8'h00, 8'h84);
    tick(3);
    chk(o_irq, 0);
    wr(8'h00, 8'h24);
    tick(3);
    chk(o_irq, 0);
    for (int s = 0; s < 2; s++) begin
      for (int d = 0; d < 2; d++) begin
        wr(8'h10, s[0] ? 8'h40 : 8'h00);
        pin <= !d[0];
        tick(4);
        wr(8'h00, 8'h00);
        pin <= d[0];
        tick(4);
        rc(8'h00, ext_exp(s[0], d[0]));
      end
    end
    wr(8'h00, 8'h92);
    tick(3);
    chk(o_irq, 1);
    wr(8'h00, 8'h82);
    tick(3);
    chk(o_irq, 0);
    wr(8'h00, 8'h00);
    repeat (3) begin
      nib <= nib ^ (4'($random(seed)) | 4'h1);
      tick(4);
      rc(8'h00, 8'h01);
      wr(8'h00, 8'h00);
    end
    wr(8'h00, 8'h89);
    tick(3);
    chk(o_irq, 1);
    wr(8'h00, 8'h81);
    tick(3);
    chk(o_irq, 0);
    c1 <= 1;
    tick(4);
    rc(8'h04, 8'h40);
    wr(8'h04, 8'h00);
    rc(8'h04, 8'h40);
    rc(8'h0C, 8'h40);
    wr(8'h04, 8'h00);
    rc(8'h04, 8'h00);
    wr(8'h04, 8'h40);
    rc(8'h04, 8'h40);
    wr(8'h08, 8'h40);
    wr(8'h00, 8'hC0);
    tick(3);
    chk(o_irq, 1);
    wr(8'h00, 8'h80);
    tick(3);
    chk(o_irq, 0);
    c1 <= 0;
    rd(8'h0C);
    wr(8'h04, 8'h00);
    c2 <= 1;
    tick(4);
    rc(8'h04, 8'h40);
    rc(8'h0C, 8'h80);
    c2 <= 0;
    rd(8'h0C);
    wr(8'h04, 8'h00);
    rc(8'h04, 8'h00);
    wr(8'h0C, 8'h07);
    tick(3);
    chk(o_cmp_power, 0);
    for (int g = 0; g < 2; g++) begin
      wr(8'h00, g ? 8'h90 : 8'h10);
      go <= 1;
      tick(1);
      go <= 0;
      pin <= 0;
      tick(4);
      chk(o_sleeping, 1);
      pin <= 1;
      tick(6);
      chk(wk, g + 1);
      chk(vc, g);
      rc(8'h0C, 8'h07);
      wr(8'h00, 8'h00);
    end
    end_sim;
  end
endmodule
